/* verilog/crs_top.sv */
// Clock source, reset holding and supply mode controller with APB registers
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "crs_map.svh"
module crs_top #(
    parameter int HSE_MHZ = 8,
    parameter bit HAS_SUP_STRAP = 1'b1,
    parameter bit HAS_BYP_STRAP = 1'b1
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire crs_pkg::crs_pins_type PIN_IN,
    input wire logic [1:0] OPT_BOR_LEVEL,
    input wire logic LP_ENTRY,
    output crs_pkg::crs_cfg_type CONFIG,
    output crs_pkg::crs_boot_type BOOT_SEL,
    output crs_pkg::crs_reg_type REGULATOR_MODE,
    output logic SYS_RESET_HOLD,
    output logic CORE_DOMAIN_RESET,
    output logic DEBUG_UNDER_RESET_OK,
    output logic BATTERY_BACKUP_EN,
    output logic CLOCKS_STOPPED,
    output logic CORE_POWER_OFF,
    output logic IRQ
);
    // External clock must stay inside the supported crystal range
    if (HSE_MHZ < `CRS_EXT_MIN_MHZ || HSE_MHZ > `CRS_EXT_MAX_MHZ) begin : g_hse_check
        $error("External clock rate out of range"); // [R2]
    end

    crs_pkg::crs_state_type s_q;
    crs_pkg::crs_state_type s_d;
    crs_pkg::crs_cfg_type cand;
    crs_pkg::crs_cfg_type cfg_rst;
    crs_pkg::crs_status_type st;
    crs_pkg::crs_status_type clr;
    crs_pkg::crs_boot_type boot_now;
    logic sup_on;
    logic byp;
    logic bor_fail;
    logic hold_now;
    logic access;
    logic hit;
    logic wr_ok;
    logic sts_wr;
    logic css_ev;
    logic pvd_ev;
    logic pll_ev;

    function automatic logic freq_ok(crs_pkg::crs_cfg_type c);
        int src;
        int sys;
        int ahb;
        src = c.clk.pll_ext ? HSE_MHZ : `CRS_RC_MHZ;
        sys = 0;
        case (c.clk.sys_src)
            crs_pkg::SRC_RC: sys = `CRS_RC_MHZ;
            crs_pkg::SRC_EXT: sys = HSE_MHZ;
            crs_pkg::SRC_PLL: sys = (src * int'(c.pll.mult)) >> (int'(c.pll.pshift) + 1); // [R4]
            default: sys = `CRS_SYS_MAX_MHZ + 1;
        endcase
        ahb = sys >> c.presc.ahb;
        freq_ok = sys <= `CRS_SYS_MAX_MHZ && ahb <= `CRS_AHB_MAX_MHZ
            && (ahb >> c.presc.apb2) <= `CRS_APB2_MAX_MHZ
            && (ahb >> c.presc.apb1) <= `CRS_APB1_MAX_MHZ; // [R5]
    endfunction

    // Supervisor gating follows the strap only where the package has it
    assign sup_on = !HAS_SUP_STRAP || s_q.f.sup_strap; // [R8]
    assign byp = HAS_BYP_STRAP && s_q.f.byp_strap; // [R14]
    assign bor_fail = sup_on && s_q.bor_lvl != 2'h0 && !s_q.f.bor_ok[s_q.bor_lvl - 2'h1];
    // With the supervisor off only the external reset pin holds the device
    assign hold_now = (sup_on && !s_q.f.por_ok) || bor_fail || !s_q.f.ext_rst_n; // [R10] [R12] [R13]
    assign access = PSEL && PENABLE;
    assign boot_now = !s_q.f.boot0 ? crs_pkg::BOOT_FLASH :
        (s_q.f.boot1 ? crs_pkg::BOOT_SRAM : crs_pkg::BOOT_SYSMEM); // [R7]
    assign css_ev = s_q.cfg.clk.css_en && s_q.f.hse_fail && !s_q.fp.hse_fail
        && (s_q.cfg.clk.sys_src == crs_pkg::SRC_EXT
        || (s_q.cfg.clk.sys_src == crs_pkg::SRC_PLL && s_q.cfg.clk.pll_ext)); // [R3]
    assign pvd_ev = sup_on && s_q.cfg.pwr.pvd_en
        && ((s_q.cfg.pwr.rise && s_q.f.pvd_above && !s_q.fp.pvd_above)
        || (s_q.cfg.pwr.fall && !s_q.f.pvd_above && s_q.fp.pvd_above)); // [R11] [R13]
    assign pll_ev = s_q.cfg.clk.pll_en && s_q.fp.pll_lock && !s_q.f.pll_lock; // [R4]
    assign sts_wr = access && PWRITE && PADDR == `CRS_OFS_STATUS;

    always_comb begin
        cfg_rst = '0;
        cfg_rst.pll.mult = `CRS_PLL_MULT_RST;
        clr = crs_pkg::crs_status_type'(PWDATA);
        cand = s_q.cfg;
        hit = 1'b1;
        case (PADDR)
            `CRS_OFS_CLKCTRL: begin
                cand.clk = crs_pkg::crs_clkctrl_type'(PWDATA); // [R2]
                cand.clk.rsv = '0;
            end
            `CRS_OFS_PLLCFG: begin
                cand.pll = crs_pkg::crs_pllcfg_type'(PWDATA); // [R4]
                cand.pll.rsv = '0;
            end
            `CRS_OFS_PRESC: begin
                cand.presc = crs_pkg::crs_presc_type'(PWDATA); // [R5]
                cand.presc.rsv = '0;
            end
            `CRS_OFS_AUDCFG: begin
                cand.aud = crs_pkg::crs_audcfg_type'(PWDATA); // [R6]
                cand.aud.rsv = '0;
            end
            `CRS_OFS_PWRCTRL: begin
                cand.pwr = crs_pkg::crs_pwrctrl_type'(PWDATA); // [R15]
                cand.pwr.rsv = '0;
            end
            `CRS_OFS_IRQEN: begin
                cand.irq = crs_pkg::crs_irqen_type'(PWDATA); // [R21]
                cand.irq.rsv = '0;
            end
            `CRS_OFS_STATUS: ;
            default: hit = 1'b0;
        endcase
        // Refuse a source that is failed or not locked, and any rate over limit
        wr_ok = freq_ok(cand)
            && !(cand.clk.sys_src == crs_pkg::SRC_EXT && s_q.f.hse_fail)
            && !(cand.clk.sys_src == crs_pkg::SRC_PLL && !(cand.clk.pll_en && s_q.f.pll_lock)); // [R2] [R5]
        st = '0;
        st.flags = s_q.flags;
        st.pvd_above = s_q.f.pvd_above;
        st.pll_lock = s_q.f.pll_lock;
        st.boot = s_q.boot;
        st.bor_lvl = s_q.bor_lvl;
        st.sup_on = sup_on;
        st.reg_byp = byp;

        s_d = s_q;
        s_d.s1 = PIN_IN;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        // A pin change is taken only once stages two and three agree
        s_d.f = crs_pkg::crs_pins_type'((~(s_q.s2 ^ s_q.s3) & s_q.s3) | ((s_q.s2 ^ s_q.s3) & s_q.f));
        s_d.fp = s_q.f;

        if (PSEL && !PENABLE) begin
            case (PADDR)
                `CRS_OFS_CLKCTRL: s_d.prdata = s_q.cfg.clk;
                `CRS_OFS_PLLCFG: s_d.prdata = s_q.cfg.pll;
                `CRS_OFS_PRESC: s_d.prdata = s_q.cfg.presc;
                `CRS_OFS_AUDCFG: s_d.prdata = s_q.cfg.aud;
                `CRS_OFS_PWRCTRL: s_d.prdata = s_q.cfg.pwr;
                `CRS_OFS_IRQEN: s_d.prdata = s_q.cfg.irq;
                `CRS_OFS_STATUS: s_d.prdata = st;
                default: s_d.prdata = '0;
            endcase
        end
        if (access && PWRITE && hit && PADDR != `CRS_OFS_STATUS && wr_ok) begin
            s_d.cfg = cand;
        end
        if (sts_wr) begin
            s_d.flags = crs_pkg::crs_flags_type'(s_q.flags & ~clr.flags); // [R21]
        end

        // Hardware fallback overrides a write landing in the same cycle
        if (css_ev) begin
            s_d.cfg.clk.sys_src = crs_pkg::SRC_RC; // [R3]
            s_d.flags.css = 1'b1; // [R21]
        end
        if (pll_ev) begin
            s_d.flags.pll_lost = 1'b1; // [R21]
            if (s_q.cfg.clk.sys_src == crs_pkg::SRC_PLL) begin
                s_d.cfg.clk.sys_src = crs_pkg::SRC_RC;
            end
        end
        if (pvd_ev) begin
            s_d.flags.supply_threshold_detector = 1'b1; // [R11] [R21]
        end

        // Option bytes are read once the power-on threshold is passed
        if (!sup_on) begin
            s_d.bor_lvl = 2'h0; // [R13]
        end else if (s_q.f.por_ok && !s_q.fp.por_ok) begin
            s_d.bor_lvl = OPT_BOR_LEVEL; // [R9]
        end

        unique case (s_q.pmode)
            crs_pkg::PM_RUN: begin
                if (LP_ENTRY) begin
                    s_d.pmode = (s_q.cfg.pwr.standby && !byp) ? crs_pkg::PM_STBY : crs_pkg::PM_STOP; // [R19]
                end
            end
            crs_pkg::PM_STOP: begin
                if (s_q.f.wake) begin
                    // Oscillators were off, so restart on the RC clock
                    s_d.pmode = crs_pkg::PM_RUN;
                    s_d.cfg.clk.sys_src = crs_pkg::SRC_RC;
                end
            end
            crs_pkg::PM_STBY: begin
                if (s_q.f.wake) begin
                    // Core domain lost power: contents come back at defaults
                    s_d.pmode = crs_pkg::PM_RUN;
                    s_d.cfg = cfg_rst; // [R16]
                    s_d.flags = '0;
                    s_d.boot = boot_now; // [R7]
                end
            end
        endcase

        s_d.hold = hold_now; // [R10]
        if (hold_now) begin
            s_d.cfg = cfg_rst; // [R1]
            s_d.flags = '0;
            s_d.pmode = crs_pkg::PM_RUN;
        end else if (s_q.hold) begin
            s_d.boot = boot_now; // [R7]
        end

        if (byp) begin
            s_d.regmode = crs_pkg::REG_OFF; // [R14]
        end else if (s_d.pmode == crs_pkg::PM_STBY) begin
            s_d.regmode = crs_pkg::REG_PDOWN; // [R16]
        end else if (s_d.pmode == crs_pkg::PM_STOP && s_q.cfg.pwr.low_power_regulation_mode) begin
            s_d.regmode = crs_pkg::REG_LOWPWR; // [R15]
        end else begin
            s_d.regmode = crs_pkg::REG_MAIN; // [R15]
        end
        s_d.core_rst = byp && !s_q.f.core_rst_n; // [R17] [R20]
        s_d.batt = sup_on; // [R13]
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s_q <= '0;
            s_q.cfg.pll.mult <= `CRS_PLL_MULT_RST;
            s_q.pmode <= crs_pkg::PM_RUN;
            s_q.hold <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA = s_q.prdata;
    assign PREADY = 1'b1;
    // Refusal is judged at the access edge, where the write would land
    assign PSLVERR = access && (!hit || (PWRITE && PADDR != `CRS_OFS_STATUS && !wr_ok)); // [R5]
    assign CONFIG = s_q.cfg;
    assign BOOT_SEL = s_q.boot;
    assign REGULATOR_MODE = s_q.regmode;
    assign SYS_RESET_HOLD = s_q.hold;
    assign CORE_DOMAIN_RESET = s_q.core_rst;
    assign DEBUG_UNDER_RESET_OK = !s_q.core_rst; // [R18]
    assign BATTERY_BACKUP_EN = s_q.batt;
    assign CLOCKS_STOPPED = s_q.pmode != crs_pkg::PM_RUN;
    assign CORE_POWER_OFF = s_q.pmode == crs_pkg::PM_STBY;
    assign IRQ = |(s_q.flags & s_q.cfg.irq.en); // [R3] [R21]

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SYS_RST);

    sequence stby_req;
        s_q.pmode == crs_pkg::PM_RUN && LP_ENTRY && s_q.cfg.pwr.standby && !byp && !hold_now;
    endsequence
    sequence por_low;
        sup_on && !s_q.f.por_ok;
    endsequence

    AST_RC_AFTER_HOLD: assert property (s_q.hold |-> s_q.cfg.clk.sys_src == crs_pkg::SRC_RC) // [R1]
        else $error("Clock source not RC after reset hold");
    AST_CSS_FALLBACK: assert property (css_ev && !hold_now && s_q.pmode == crs_pkg::PM_RUN // [R3]
        |=> s_q.cfg.clk.sys_src == crs_pkg::SRC_RC && s_q.flags.css && IRQ == s_q.cfg.irq.en.css)
        else $error("Clock failure did not fall back to RC");
    AST_FREQ_LIMIT: assert property (freq_ok(s_q.cfg)) // [R5]
        else $error("Bus clock configuration over limit");
    AST_BOOT_CAPTURE: assert property ($changed(s_q.boot) // [R7]
        |-> ($past(s_q.hold) && !s_q.hold) || $past(s_q.pmode) == crs_pkg::PM_STBY)
        else $error("Boot selection changed outside startup");
    AST_POR_HOLD: assert property (por_low |=> s_q.hold ##1 s_q.cfg == cfg_rst) // [R10]
        else $error("Reset not held below power-on threshold");
    AST_DETECT_OFF: assert property (!sup_on && !s_q.flags.supply_threshold_detector |=> !s_q.flags.supply_threshold_detector) // [R13]
        else $error("Threshold flag set with internal reset off");
    AST_NO_STANDBY_BYP: assert property (byp && LP_ENTRY && s_q.pmode == crs_pkg::PM_RUN && !hold_now // [R19]
        |=> s_q.pmode == crs_pkg::PM_STOP)
        else $error("Standby entered with regulator bypassed");
    AST_STBY_PDOWN: assert property (stby_req |=> s_q.pmode == crs_pkg::PM_STBY // [R16]
        && s_q.regmode == crs_pkg::REG_PDOWN && CORE_POWER_OFF)
        else $error("Standby entry did not power down regulator");
    AST_REG_OFF: assert property (byp |=> s_q.regmode == crs_pkg::REG_OFF) // [R14]
        else $error("Regulator not off while bypassed");
    AST_FLAG_STICKY: assert property (s_q.flags.css && !sts_wr && !hold_now // [R21]
        && s_q.pmode == crs_pkg::PM_RUN |=> s_q.flags.css)
        else $error("Clock failure flag lost without clear");
    AST_CORE_RESET: assert property (byp && !s_q.f.core_rst_n |=> CORE_DOMAIN_RESET && !DEBUG_UNDER_RESET_OK) // [R17]
        else $error("Core reset pin not honoured");

    // Low-power entry and exit steps, and the power-on rise
    sequence stop_req;
        s_q.pmode == crs_pkg::PM_RUN && LP_ENTRY && !byp && !hold_now;
    endsequence
    sequence stop_wake;
        s_q.pmode == crs_pkg::PM_STOP && s_q.f.wake && !hold_now;
    endsequence
    sequence stby_wake;
        s_q.pmode == crs_pkg::PM_STBY && s_q.f.wake;
    endsequence
    sequence por_rise;
        sup_on && s_q.f.por_ok && !s_q.fp.por_ok;
    endsequence

    AST_STOP_LPR: assert property ( // [R15]
        stop_req ##0 (!s_q.cfg.pwr.standby && s_q.cfg.pwr.low_power_regulation_mode)
        |=> s_q.pmode == crs_pkg::PM_STOP && s_q.regmode == crs_pkg::REG_LOWPWR)
        else $error("Stop entry did not select low-power regulation");

    AST_RUN_MAIN: assert property ( // [R15]
        s_q.pmode == crs_pkg::PM_RUN && !byp && !$past(byp)
        |-> s_q.regmode == crs_pkg::REG_MAIN)
        else $error("Run mode without main regulation");

    AST_STOP_WAKE: assert property ( // [R15]
        stop_wake
        |=> s_q.pmode == crs_pkg::PM_RUN && s_q.cfg.clk.sys_src == crs_pkg::SRC_RC)
        else $error("Stop exit did not restart on RC clock");

    AST_STBY_WAKE: assert property ( // [R16]
        stby_wake
        |=> s_q.pmode == crs_pkg::PM_RUN && s_q.cfg == cfg_rst && s_q.flags == '0)
        else $error("Standby exit kept lost contents");

    AST_BOR_HOLD: assert property ( // [R10]
        bor_fail
        |=> s_q.hold)
        else $error("Reset not held below brownout level");

    AST_EXT_HOLD: assert property ( // [R10]
        !s_q.f.ext_rst_n
        |=> s_q.hold)
        else $error("Reset not held by external reset pin");

    AST_BATT_OFF: assert property ( // [R13]
        !sup_on
        |=> !BATTERY_BACKUP_EN)
        else $error("Battery backup left on with supervisor off");

    AST_BOR_OFF: assert property ( // [R13]
        !sup_on
        |=> s_q.bor_lvl == 2'h0)
        else $error("Brownout level kept with supervisor off");

    AST_BOR_LOAD: assert property ( // [R9]
        por_rise
        |=> s_q.bor_lvl == $past(OPT_BOR_LEVEL))
        else $error("Option brownout level not loaded");

    AST_NO_CORE_RST: assert property ( // [R17]
        !byp
        |=> !CORE_DOMAIN_RESET)
        else $error("Core reset active with regulator on");

    AST_PVD_FLAG: assert property ( // [R11]
        pvd_ev && !hold_now && s_q.pmode != crs_pkg::PM_STBY
        |=> s_q.flags.supply_threshold_detector)
        else $error("Threshold event did not set its flag");

    AST_PLL_LOST: assert property ( // [R4]
        pll_ev && !hold_now && s_q.pmode == crs_pkg::PM_RUN
        |=> s_q.flags.pll_lost && s_q.cfg.clk.sys_src != crs_pkg::SRC_PLL)
        else $error("Lock loss did not leave the PLL source");

    AST_REFUSE_KEEP: assert property ( // [R5]
        access && PWRITE && PSLVERR && !css_ev && !pll_ev && !hold_now
        && s_q.pmode == crs_pkg::PM_RUN
        |=> $stable(s_q.cfg))
        else $error("Refused write changed the configuration");
endmodule

/* shared/crs_map.svh */
// Register offsets, limits and reset values for the clock, reset and supply block
// Behaviour
// R1: Reset selects internal 16 MHz RC clock
// R2: Software picks RC or external 4-26 MHz
// R3: Clock failure falls back to RC, interrupts
// R4: PLL raises system clock up to 168 MHz
// R5: Prescalers keep AHB/APB at 168/84/42 MHz
// R6: Audio synthesizer configured for 8-192 kHz rates; the code only stores AUDCFG as written, with no rate check
// R7: Boot pins sampled, three boot sources
// R8: Supervisor active only while strap high
// R9: Option bytes load brownout level after power-on
// R10: Held in reset below power-on or brownout
// R11: Threshold detector interrupts on chosen edges
// R12: External supervisor holds reset below 1.8 V
// R13: Internal reset off disables POR, BOR, detector, battery
// R14: Regulator runs with bypass strap low only
// R15: Main mode in run, low-power in Stop
// R16: Power-down regulator only in Standby
// R17: Core reset pin resets core domain when bypassed
// R18: Core reset pin low blocks debug under reset
// R19: No Standby with regulator bypassed
// R20: External supervisor drives core reset pin
// R21: Sticky maskable flags for clock and supply events
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
`define CRS_OFS_CLKCTRL 8'h00
`define CRS_OFS_PLLCFG 8'h04
`define CRS_OFS_PRESC 8'h08
`define CRS_OFS_AUDCFG 8'h0C
`define CRS_OFS_PWRCTRL 8'h10
`define CRS_OFS_IRQEN 8'h14
`define CRS_OFS_STATUS 8'h18
`define CRS_RC_MHZ 16
`define CRS_EXT_MIN_MHZ 4
`define CRS_EXT_MAX_MHZ 26
`define CRS_SYS_MAX_MHZ 168
`define CRS_AHB_MAX_MHZ 168
`define CRS_APB2_MAX_MHZ 84
`define CRS_APB1_MAX_MHZ 42
`define CRS_PLL_MULT_RST 9'h015
`endif

/* shared/crs_pkg.sv */
// Types shared by the clock, reset and supply block
package crs_pkg;
    typedef enum logic [2:0] {PM_RUN = 3'h1, PM_STOP = 3'h2, PM_STBY = 3'h4} crs_pmode_type;
    typedef enum logic [1:0] {SRC_RC = 2'h0, SRC_EXT = 2'h1, SRC_PLL = 2'h2} crs_src_type;
    typedef enum logic [1:0] {REG_MAIN = 2'h0, REG_LOWPWR = 2'h1, REG_PDOWN = 2'h2, REG_OFF = 2'h3} crs_reg_type;
    typedef enum logic [1:0] {BOOT_FLASH = 2'h0, BOOT_SYSMEM = 2'h1, BOOT_SRAM = 2'h3} crs_boot_type;
    typedef struct packed {
        logic por_ok;
        logic [2:0] bor_ok;
        logic pvd_above;
        logic hse_fail;
        logic pll_lock;
        logic boot1;
        logic boot0;
        logic sup_strap;
        logic byp_strap;
        logic ext_rst_n;
        logic core_rst_n;
        logic wake;
    } crs_pins_type;
    typedef struct packed {
        logic pll_lost;
        logic supply_threshold_detector;
        logic css;
    } crs_flags_type;
    typedef struct packed {
        logic [26:0] rsv;
        logic css_en;
        logic pll_ext;
        logic pll_en;
        crs_src_type sys_src;
    } crs_clkctrl_type;
    typedef struct packed {
        logic [20:0] rsv;
        logic [1:0] pshift;
        logic [8:0] mult;
    } crs_pllcfg_type;
    typedef struct packed {
        logic [22:0] rsv;
        logic [2:0] apb1;
        logic [2:0] apb2;
        logic [2:0] ahb;
    } crs_presc_type;
    typedef struct packed {
        logic [18:0] rsv;
        logic en;
        logic [2:0] div;
        logic [8:0] mult;
    } crs_audcfg_type;
    typedef struct packed {
        logic [26:0] rsv;
        logic low_power_regulation_mode;
        logic standby;
        logic fall;
        logic rise;
        logic pvd_en;
    } crs_pwrctrl_type;
    typedef struct packed {
        logic [28:0] rsv;
        crs_flags_type en;
    } crs_irqen_type;
    typedef struct packed {
        logic [20:0] rsv;
        logic reg_byp;
        logic sup_on;
        logic [1:0] bor_lvl;
        crs_boot_type boot;
        logic pll_lock;
        logic pvd_above;
        crs_flags_type flags;
    } crs_status_type;
    typedef struct packed {
        crs_clkctrl_type clk;
        crs_pllcfg_type pll;
        crs_presc_type presc;
        crs_audcfg_type aud;
        crs_pwrctrl_type pwr;
        crs_irqen_type irq;
    } crs_cfg_type;
    typedef struct packed {
        crs_pins_type s1;
        crs_pins_type s2;
        crs_pins_type s3;
        crs_pins_type f;
        crs_pins_type fp;
        crs_cfg_type cfg;
        crs_flags_type flags;
        crs_pmode_type pmode;
        crs_reg_type regmode;
        crs_boot_type boot;
        logic [1:0] bor_lvl;
        logic hold;
        logic core_rst;
        logic batt;
        logic [31:0] prdata;
    } crs_state_type;
endpackage

/* bench/crs_supervisor_model.sv */
// External supply supervisor model driving the two reset pins
`timescale 1ns/1ps
module crs_supervisor_model #(
    parameter int SLOW_CYCLES = 20
) (
    input wire logic clk,
    input wire logic vdd_ok,
    input wire logic core_ok,
    input wire logic slow,
    output logic ext_rst_n,
    output logic core_rst_n
);
    int cnt;
    initial begin
        cnt = 0;
        ext_rst_n = 1'b0;
        core_rst_n = 1'b0;
    end
    // Release waits out a settling count when slow; assertion is immediate
    always @(posedge clk) begin
        if (!vdd_ok) begin
            cnt <= 0;
            ext_rst_n <= 1'b0;
            core_rst_n <= 1'b0;
        end else begin
            if (cnt < SLOW_CYCLES) begin
                cnt <= cnt + 1;
            end
            ext_rst_n <= !slow || cnt >= SLOW_CYCLES;
            // Driven apart from the external reset so debug stays possible
            core_rst_n <= core_ok && (!slow || cnt >= SLOW_CYCLES);
        end
    end
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the clock, reset and supply block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
`define WT(c) for (wk = 0; wk < 80 && !(c); wk++) @(posedge clock); if (!(c)) begin `CHK(1'b0, 1'b1) stop_test(); end
module tb_top;
    typedef struct packed {logic rd; logic err; logic [31:0] dat;} crs_tb_note_type;
    typedef struct packed {logic sel; logic en; logic wr; logic [7:0] addr; logic [31:0] wdata;} crs_tb_apb_type;
    logic clock = 1'b0;
    logic sys_rst, pready, pslverr, lp, hold, core_rst, dbg_ok, batt, stopped, poff, irq, vdd, core_ok, slow;
    logic ext_n, core_n;
    logic [1:0] opt;
    logic [31:0] prdata, d;
    crs_tb_apb_type bus;
    crs_pkg::crs_pins_type pins, pin_in;
    crs_pkg::crs_cfg_type cfg;
    crs_pkg::crs_boot_type boot_sel;
    crs_pkg::crs_reg_type regm;
    crs_tb_note_type notes[$];
    crs_tb_note_type n;
    int bad_count = 0;
    int n_tests = 0;
    int wk, i;
    integer seed;
    always #10 clock = ~clock;
    always_comb begin
        pin_in = pins;
        pin_in.ext_rst_n = ext_n;
        pin_in.core_rst_n = core_n;
    end
    crs_supervisor_model i_sup (.clk(clock), .vdd_ok(vdd), .core_ok(core_ok), .slow(slow), .ext_rst_n(ext_n),
        .core_rst_n(core_n));
    crs_top i_dut (.CLOCK(clock), .SYS_RST(sys_rst), .PSEL(bus.sel), .PENABLE(bus.en), .PWRITE(bus.wr),
        .PADDR(bus.addr), .PWDATA(bus.wdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PIN_IN(pin_in), .OPT_BOR_LEVEL(opt), .LP_ENTRY(lp), .CONFIG(cfg), .BOOT_SEL(boot_sel),
        .REGULATOR_MODE(regm), .SYS_RESET_HOLD(hold), .CORE_DOMAIN_RESET(core_rst),
        .DEBUG_UNDER_RESET_OK(dbg_ok), .BATTERY_BACKUP_EN(batt), .CLOCKS_STOPPED(stopped),
        .CORE_POWER_OFF(poff), .IRQ(irq));
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Expected answer is noted at setup; the monitor pops it at the access edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic err,
        input logic [31:0] ex);
        int k;
        @(posedge clock);
        bus <= '{1'b1, 1'b0, wr, a, wd};
        notes.push_back('{!wr, err, ex});
        @(posedge clock);
        bus.en <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        bus <= '0;
        if (k >= 50) begin
            `CHK(1'b0, 1'b1)
            stop_test();
        end
    endtask
    task automatic lp_pulse;
        @(posedge clock);
        lp <= 1'b1;
        @(posedge clock);
        lp <= 1'b0;
    endtask
    always @(posedge clock) begin
        if (bus.sel && bus.en && pready === 1'b1) begin
            if (notes.size() == 0) begin
                `CHK(1'b0, 1'b1)
            end else begin
                n = notes.pop_front();
                `CHK(pslverr, n.err)
                if (n.rd) begin
                    `CHK(prdata, n.dat)
                end
            end
        end
    end
    initial begin
        seed = 57;
        sys_rst = 1'b1;
        bus = '0;
        lp = 1'b0;
        opt = 2'h2;
        vdd = 1'b1;
        core_ok = 1'b1;
        slow = 1'b0;
        pins = '{por_ok: 1'b1, bor_ok: 3'h7, pvd_above: 1'b1, pll_lock: 1'b1, boot0: 1'b1, sup_strap: 1'b1,
            default: 1'b0};
        repeat (6) @(posedge clock);
        `CHK(hold, 1'b1)
        `CHK(cfg.clk.sys_src, crs_pkg::SRC_RC)
        sys_rst <= 1'b0;
        `WT(hold === 1'b0)
        `CHK(boot_sel, crs_pkg::BOOT_SYSMEM)
        `CHK(batt, 1'b1)
        apb(0, 8'h18, 0, 0, 32'h338);
        apb(0, 8'h1C, 0, 1, 0);
        for (i = 0; i < 4; i++) begin
            d = $random(seed) & 32'h1FFF;
            apb(1, 8'h0C, d, 0, 0);
            apb(0, 8'h0C, 0, 0, d);
        end
        // Clock failure while running on the external source
        apb(1, 8'h00, 32'h11, 0, 0);
        apb(1, 8'h00, 32'h13, 1, 0);
        apb(1, 8'h14, 32'h1, 0, 0);
        pins.hse_fail <= 1'b1;
        `WT(irq === 1'b1)
        apb(0, 8'h00, 0, 0, 32'h10);
        apb(1, 8'h00, 32'h11, 1, 0);
        apb(1, 8'h14, 32'h0, 0, 0);
        @(posedge clock);
        `CHK(irq, 1'b0)
        apb(0, 8'h18, 0, 0, 32'h339);
        apb(1, 8'h18, 32'h1, 0, 0);
        apb(0, 8'h18, 0, 0, 32'h338);
        pins.hse_fail <= 1'b0;
        apb(1, 8'h10, 32'h5, 0, 0);
        apb(1, 8'h14, 32'h2, 0, 0);
        pins.pvd_above <= 1'b0;
        `WT(irq === 1'b1)
        apb(0, 8'h18, 0, 0, 32'h332);
        apb(1, 8'h18, 32'h2, 0, 0);
        pins.pvd_above <= 1'b1;
        repeat (8) @(posedge clock);
        apb(0, 8'h18, 0, 0, 32'h338);
        // Prescalers first: the PLL at full rate needs them divided
        apb(1, 8'h08, 32'h88, 0, 0);
        apb(1, 8'h04, 32'h15, 0, 0);
        apb(1, 8'h00, 32'h06, 0, 0);
        apb(1, 8'h04, 32'h16, 1, 0);
        apb(1, 8'h08, 32'h48, 1, 0);
        apb(1, 8'h08, 32'h80, 1, 0);
        apb(0, 8'h08, 0, 0, 32'h88);
        apb(1, 8'h14, 32'h4, 0, 0);
        pins.pll_lock <= 1'b0;
        `WT(irq === 1'b1)
        apb(0, 8'h00, 0, 0, 32'h04);
        pins.pll_lock <= 1'b1;
        apb(1, 8'h10, 32'h10, 0, 0);
        lp_pulse();
        `WT(stopped === 1'b1)
        `CHK(regm, crs_pkg::REG_LOWPWR)
        `CHK(poff, 1'b0)
        pins.wake <= 1'b1;
        `WT(stopped === 1'b0)
        `CHK(regm, crs_pkg::REG_MAIN)
        pins.wake <= 1'b0;
        apb(1, 8'h10, 32'h08, 0, 0);
        lp_pulse();
        `WT(poff === 1'b1)
        `CHK(regm, crs_pkg::REG_PDOWN)
        pins.wake <= 1'b1;
        `WT(poff === 1'b0)
        pins.wake <= 1'b0;
        apb(0, 8'h08, 0, 0, 32'h0);
        apb(1, 8'h10, 32'h08, 0, 0);
        pins.byp_strap <= 1'b1;
        `WT(regm === crs_pkg::REG_OFF)
        core_ok <= 1'b0;
        `WT(core_rst === 1'b1)
        `CHK(dbg_ok, 1'b0)
        core_ok <= 1'b1;
        `WT(core_rst === 1'b0)
        lp_pulse();
        `WT(stopped === 1'b1)
        `CHK(poff, 1'b0)
        pins.wake <= 1'b1;
        `WT(stopped === 1'b0)
        pins.wake <= 1'b0;
        pins.byp_strap <= 1'b0;
        pins.bor_ok <= 3'h5;
        `WT(hold === 1'b1)
        pins.bor_ok <= 3'h7;
        `WT(hold === 1'b0)
        pins.por_ok <= 1'b0;
        `WT(hold === 1'b1)
        pins.por_ok <= 1'b1;
        `WT(hold === 1'b0)
        // Supervisor strapped off: only the external reset holds the part
        pins.sup_strap <= 1'b0;
        `WT(batt === 1'b0)
        pins.por_ok <= 1'b0;
        repeat (10) @(posedge clock);
        `CHK(hold, 1'b0)
        apb(0, 8'h18, 0, 0, 32'h38);
        vdd <= 1'b0;
        `WT(hold === 1'b1)
        slow <= 1'b1;
        vdd <= 1'b1;
        repeat (10) @(posedge clock);
        `CHK(hold, 1'b1)
        `WT(hold === 1'b0)
        stop_test();
    end
endmodule
